// ==== bench/caf_host_model.sv ====
// host side of the register port: byte writes, byte reads, ready poll and mode change
// assumes it shares CLK with the block and is the only master on the port
`timescale 1ns/1ps
module caf_host_model (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  // idle port at time zero
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // one-cycle write strobe; data is scrambled after release so nothing leans on a stale value
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask

  // one-cycle read strobe; read data stands only in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // the device does not refuse early access, so the host holds off until ready
  task automatic wait_ready(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      rd_reg(8'h01, s);
      ok = (s[0] === 1'b1);
    end
  endtask

  // request a mode, then confirm it in the status register
  task automatic set_mode(input logic [2:0] m, output logic ok);
    logic [7:0] s;
    wr_reg(8'h00, {m, 5'h00});
    rd_reg(8'h01, s);
    ok = (s[7:5] === m);
  endtask
endmodule

// ==== bench/caf_top_tb.sv ====
// self-checking bench of the acceptance filter and configuration block
// assumes the host model drives the register port and this module drives messages
`timescale 1ns/1ps
module caf_top_tb;
  import caf_pkg::*;
  logic        CLK       = 1'b0;
  logic        RST_B     = 1'b0;
  logic        MSG_VALID = 1'b0;
  logic        MSG_EXT   = 1'b0;
  logic [28:0] MSG_ID    = 29'h0;
  logic [7:0]  ADDR, WDATA, RDATA;
  logic        WR, RD, ACC_VALID, ACC_BUF, TQ_TICK, BIT_START, SAMPLE_POINT, CONFIG_MODE;
  logic [2:0]  ACC_FILTER;
  logic        ok;
  int          fail_count = 0;
  int          checked    = 0;
  int          cyc        = 0;

  always #10 CLK = ~CLK;

  caf_top dut (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .MSG_VALID(MSG_VALID), .MSG_EXT(MSG_EXT), .MSG_ID(MSG_ID), .ACC_VALID(ACC_VALID), .ACC_BUF(ACC_BUF),
    .ACC_FILTER(ACC_FILTER), .TQ_TICK(TQ_TICK), .BIT_START(BIT_START), .SAMPLE_POINT(SAMPLE_POINT),
    .CONFIG_MODE(CONFIG_MODE));
  caf_host_model host (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD), .rdata(RDATA));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hang costs at most a few thousand cycles; the whole run needs well under that
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] d;
    host.rd_reg(a, d);
    check(d & m, exp);
  endtask

  // bank image: mask0 and filters 0-1 all ones, mask1 covers the standard id, filters 2-5 a0..a3
  function automatic logic [7:0] bank_val(int s, int b);
    if (s == 1) return (b == 0) ? 8'hff : (b == 1) ? 8'he0 : 8'h00;
    if (s >= 4) return (b == 0) ? 8'ha0 + 8'(s - 4) : 8'h00;
    return 8'hff;
  endfunction

  // one message; acceptance is judged in the cycle after it is taken
  task automatic msg(input logic ext, input logic [28:0] id, input logic acc, input logic [3:0] exp);
    @(posedge CLK);
    MSG_VALID <= 1'b1;
    MSG_EXT   <= ext;
    MSG_ID    <= id;
    @(posedge CLK);
    MSG_VALID <= 1'b0;
    MSG_ID    <= ~id;
    #1;
    check(ACC_VALID, acc);
    if (acc) check({ACC_BUF, ACC_FILTER}, exp);
  endtask

  function automatic logic sel(int k);
    return (k == 0) ? TQ_TICK : (k == 1) ? BIT_START : SAMPLE_POINT;
  endfunction

  task automatic count_to(int k, output int n);
    n = 0;
    do begin
      @(posedge CLK);
      #1 n++;
    end while (sel(k) !== 1'b1 && n < 300);
  endtask

  task automatic t_reset;
    rchk(8'h00, 8'hff, 8'h80);
    rchk(8'h01, 8'he1, 8'h80);
    host.wait_ready(ok);
    check(ok, 1'b1);
  endtask

  task automatic t_config;
    host.wr_reg(8'h02, 8'h07);
    host.wr_reg(8'h03, 8'h90);
    host.wr_reg(8'h04, 8'h02);
    for (int s = 0; s < 8; s++)
      for (int b = 0; b < 4; b++)
        host.wr_reg(8'h10 + 8'(4 * s + b), bank_val(s, b));
    rchk(8'h02, 8'h3f, 8'h07);
    rchk(8'h19, 8'hff, 8'hff);
    msg(1'b0, {18'h0, 8'ha0, 3'h0}, 1'b0, 4'h0);
  endtask

  task automatic t_normal;
    host.set_mode(3'h0, ok);
    check(ok, 1'b1);
    check(CONFIG_MODE, 1'b0);
    host.wr_reg(8'h02, 8'h3f);
    rchk(8'h02, 8'h3f, 8'h07);
    host.wr_reg(8'h20, 8'h55);
    rchk(8'h20, 8'hff, 8'ha0);
  endtask

  // quantum 2*(7+1) clocks; bit 1+1+3+3 quanta, sample point after 5 of them
  task automatic t_timing;
    int n;
    count_to(0, n);
    count_to(0, n);
    check(n, 16);
    count_to(1, n);
    count_to(2, n);
    check(n, 80);
    count_to(1, n);
    check(n, 48);
  endtask

  task automatic t_accept;
    for (int k = 0; k < 4; k++) begin
      msg(1'b0, {18'h0, 8'ha0 + 8'(k), 3'h0}, 1'b1, {1'b1, 3'(k + 2)});
      rchk(8'h06, 8'h07, 8'(k + 2));
    end
    msg(1'b0, {18'h0, 8'ha0, 3'h1}, 1'b0, 4'h0);
    msg(1'b0, {18'h0, 8'ha4, 3'h0}, 1'b0, 4'h0);
    msg(1'b0, 29'h7ff, 1'b0, 4'h0);
    msg(1'b1, {8'ha0, 3'h0, 18'h0}, 1'b0, 4'h0);
    msg(1'b1, 29'h1fffffff, 1'b1, 4'h0);
    rchk(8'h05, 8'h01, 8'h00);
    msg(1'b1, 29'h1ffffffe, 1'b0, 4'h0);
  endtask

  task automatic t_soft;
    host.wr_reg(8'h07, 8'h00);
    @(posedge CLK);
    #1 check(CONFIG_MODE, 1'b1);
    rchk(8'h00, 8'hff, 8'h80);
    rchk(8'h06, 8'h07, 8'h00);
    rchk(8'h02, 8'hff, 8'h00);
    rchk(8'h08, 8'hff, 8'h00);
    msg(1'b0, {18'h0, 8'ha2, 3'h0}, 1'b0, 4'h0);
  endtask

  // reset held five cycles; first request only after the internal release
  initial begin
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    #1 check(CONFIG_MODE, 1'b1);
    repeat (2) @(posedge CLK);
    t_reset();
    t_config();
    t_normal();
    t_timing();
    t_accept();
    t_soft();
    report_and_stop();
  end
endmodule

// ==== rtl/caf_match.sv ====
// per-filter identifier compare under the owning buffer mask
// assumes msg_id is already aligned: standard ids in the top eleven bits
`timescale 1ns/1ps
module caf_match (
  caf_match_if.matcher mi
);
  import caf_pkg::*;
  // standard frames only compare the eleven standard bits
  localparam logic [ID_W-1:0] STD_CARE = {{STD_W{1'b1}}, {EXT_W{1'b0}}};
  wire [ID_W-1:0] care = mi.msg_ext ? {ID_W{1'b1}} : STD_CARE;

  // filters 0..1 use mask 0, filters 2..5 use mask 1
  for (genvar f = 0; f < N_FILT; f++) begin : g_filt
    localparam int M = (f < N_BUF0_FILT) ? 0 : 1;
    wire [ID_W-1:0] diff = (mi.msg_id ^ mi.filt[f]) & mi.mask[M] & care;
    assign mi.hit[f] = (mi.extended_id_enable[f] == mi.msg_ext) && (diff == '0);
  end
endmodule

// ==== rtl/caf_match_if.sv ====
// carrier between the register side and the identifier matcher
// assumes both ends sit on the same clock; the matcher is combinational
`timescale 1ns/1ps
interface caf_match_if;
  import caf_pkg::*;
  logic [N_MASK-1:0][ID_W-1:0] mask;
  logic [N_FILT-1:0][ID_W-1:0] filt;
  logic [N_FILT-1:0]           extended_id_enable;
  logic [ID_W-1:0]             msg_id;
  logic                        msg_ext;
  logic [N_FILT-1:0]           hit;
  modport cfg     (output mask, filt, extended_id_enable, msg_id, msg_ext, input hit);
  modport matcher (input mask, filt, extended_id_enable, msg_id, msg_ext, output hit);
endinterface

// ==== rtl/caf_pkg.sv ====
// shared constants of the acceptance filter and configuration block
// assumes one oscillator clock domain and an 8-bit register port
package caf_pkg;
  // widths
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 8;
  localparam int ID_W        = 29;
  localparam int STD_W       = 11;
  localparam int EXT_W       = 18;
  localparam int N_FILT      = 6;
  localparam int N_MASK      = 2;
  localparam int N_BUF0_FILT = 2;
  localparam int FILT_IDX_W  = 3;
  localparam int BRP_W       = 6;
  localparam int SEG_W       = 3;
  localparam int DIV_W       = 8;
  localparam int QNT_W       = 5;
  localparam int CNT_W       = 8;
  localparam int BANK_IDX_W  = 5;
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAT   = 8'h01;
  localparam logic [ADDR_W-1:0] OFF_CFG1   = 8'h02;
  localparam logic [ADDR_W-1:0] OFF_CFG2   = 8'h03;
  localparam logic [ADDR_W-1:0] OFF_CFG3   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RX0CTL = 8'h05;
  localparam logic [ADDR_W-1:0] OFF_RX1CTL = 8'h06;
  localparam logic [ADDR_W-1:0] OFF_RESET  = 8'h07;
  localparam logic [ADDR_W-1:0] OFF_BANK   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_BANK_END = 8'h2f;
  // bank layout: four bytes per set, sets 0..1 masks, 2..7 filters 0..5
  localparam int BYTES_PER_SET = 4;
  localparam int BANK_BYTES    = 32;
  localparam int FILT_SET0     = 2;
  localparam int B_SIDH        = 0;
  localparam int B_SIDL        = 1;
  localparam int B_EID8        = 2;
  localparam int B_EID0        = 3;
  // field positions
  localparam int MODE_HI     = 7;
  localparam int MODE_LO     = 5;
  localparam int PROP_LO     = 0;
  localparam int PS1_LO      = 3;
  localparam int PS2_LO      = 0;
  localparam int EXTENDED_ID_ENABLE_BIT   = 3;
  localparam int SIDL_ID_HI  = 7;
  localparam int SIDL_ID_LO  = 5;
  localparam int SIDL_EID_HI = 1;
  localparam int STAT_RDY    = 0;
  // mode codes and reset values
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_CONFIG = 3'h4;
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  // oscillator start-up time in oscillator cycles
  localparam int OSC_START_CYC = 128;
endpackage

// ==== rtl/caf_top.sv ====
// configuration mode, bit timing and message acceptance of a can controller
// assumes register port and message inputs are synchronous to CLK
`timescale 1ns/1ps
module caf_top (
  input  wire logic                        CLK,
  input  wire logic                        RST_B,
  input  wire logic [caf_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [caf_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR,
  input  wire logic                        RD,
  output logic      [caf_pkg::DATA_W-1:0]  RDATA,
  input  wire logic                        MSG_VALID,
  input  wire logic                        MSG_EXT,
  input  wire logic [caf_pkg::ID_W-1:0]    MSG_ID,
  output logic                             ACC_VALID,
  output logic                             ACC_BUF,
  output logic      [caf_pkg::FILT_IDX_W-1:0] ACC_FILTER,
  output logic                             TQ_TICK,
  output logic                             BIT_START,
  output logic                             SAMPLE_POINT,
  output logic                             CONFIG_MODE
);
  import caf_pkg::*;

  // quantum divider: 2 * (prescaler + 1)
  function automatic logic [DIV_W-1:0] tq_div(input logic [BRP_W-1:0] baud_prescaler);
    logic [DIV_W-1:0] d;
    d = {1'b0, baud_prescaler, 1'b0} + DIV_W'(2);
    return d;
  endfunction

  // a segment field value n stands for n+1 quanta
  function automatic logic [QNT_W-1:0] seg_q(input logic [SEG_W-1:0] s);
    return QNT_W'(s) + QNT_W'(1);
  endfunction

  // lowest set filter among the given range
  function automatic logic [FILT_IDX_W-1:0] first_hit(input logic [N_FILT-1:0] h, input int lo);
    logic [FILT_IDX_W-1:0] r;
    r = '0;
    for (int i = N_FILT - 1; i >= lo; i--) begin
      if (h[i]) r = FILT_IDX_W'(i);
    end
    return r;
  endfunction

  // reset release through two flops
  logic rst_s1_q, rst_n;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // register state
  logic [2:0]        req_mode_q, cur_mode_q;
  logic [DATA_W-1:0] cfg1_q, cfg2_q, cfg3_q;
  logic [DATA_W-1:0] bank_q [BANK_BYTES];
  logic              rx0_hit_q;
  logic [FILT_IDX_W-1:0] rx1_hit_q;
  logic              soft_rst_q;
  logic [CNT_W-1:0]  start_cnt_q;
  logic              osc_rdy_q;

  // address decode
  wire in_cfg     = (cur_mode_q == MODE_CONFIG);
  wire hit_ctrl   = (ADDR == OFF_CTRL);
  wire hit_cfg1   = (ADDR == OFF_CFG1);
  wire hit_cfg2   = (ADDR == OFF_CFG2);
  wire hit_cfg3   = (ADDR == OFF_CFG3);
  wire hit_reset  = (ADDR == OFF_RESET);
  wire hit_bank   = (ADDR >= OFF_BANK) && (ADDR <= OFF_BANK_END);
  wire [BANK_IDX_W-1:0] bank_idx = BANK_IDX_W'(ADDR - OFF_BANK);
  wire wr_cfg_ok  = WR && in_cfg;
  wire wr_bank_ok = WR && hit_bank && in_cfg;

  // soft reset command: one cycle pulse that clears like a power-up
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) soft_rst_q <= 1'b0;
    else        soft_rst_q <= WR && hit_reset;
  end

  // mode control; a reset of either kind lands in configuration
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      req_mode_q <= MODE_CONFIG;
      cur_mode_q <= MODE_CONFIG;
    end else if (soft_rst_q) begin
      req_mode_q <= MODE_CONFIG;
      cur_mode_q <= MODE_CONFIG;
    end else begin
      if (WR && hit_ctrl) req_mode_q <= WDATA[MODE_HI:MODE_LO];
      cur_mode_q <= req_mode_q;
    end
  end

  // start-up counter; accesses before ready are the host's risk, status shows it
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      start_cnt_q <= '0;
      osc_rdy_q   <= 1'b0;
    end else if (soft_rst_q) begin
      start_cnt_q <= '0;
      osc_rdy_q   <= 1'b0;
    end else if (!osc_rdy_q) begin
      start_cnt_q <= start_cnt_q + CNT_W'(1);
      osc_rdy_q   <= (start_cnt_q == CNT_W'(OSC_START_CYC - 1));
    end
  end

  // bit timing registers, locked outside configuration
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg1_q <= RST_BYTE;
      cfg2_q <= RST_BYTE;
      cfg3_q <= RST_BYTE;
    end else if (soft_rst_q) begin
      cfg1_q <= RST_BYTE;
      cfg2_q <= RST_BYTE;
      cfg3_q <= RST_BYTE;
    end else if (wr_cfg_ok) begin
      if (hit_cfg1) cfg1_q <= WDATA;
      if (hit_cfg2) cfg2_q <= WDATA;
      if (hit_cfg3) cfg3_q <= WDATA;
    end
  end

  // mask and filter bank, locked outside configuration
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < BANK_BYTES; i++) bank_q[i] <= RST_BYTE;
    end else if (soft_rst_q) begin
      for (int i = 0; i < BANK_BYTES; i++) bank_q[i] <= RST_BYTE;
    end else if (wr_bank_ok) begin
      bank_q[bank_idx] <= WDATA;
    end
  end

  // identifier layout of a set: high byte, low top three, two eid bits, eid bytes
  // bytes come in as arguments so the continuous assigns below see every bank change
  function automatic logic [ID_W-1:0] set_id(input logic [DATA_W-1:0] hi,
                                             input logic [DATA_W-1:0] lo,
                                             input logic [DATA_W-1:0] e8,
                                             input logic [DATA_W-1:0] e0);
    return {hi, lo[SIDL_ID_HI:SIDL_ID_LO], lo[SIDL_EID_HI:0], e8, e0};
  endfunction

  // matcher hookup; standard ids sit in the top eleven compare bits
  caf_match_if mif ();
  for (genvar m = 0; m < N_MASK; m++) begin : g_mask
    assign mif.mask[m] = set_id(bank_q[m*BYTES_PER_SET + B_SIDH], bank_q[m*BYTES_PER_SET + B_SIDL],
                                bank_q[m*BYTES_PER_SET + B_EID8], bank_q[m*BYTES_PER_SET + B_EID0]);
  end
  for (genvar f = 0; f < N_FILT; f++) begin : g_flt
    assign mif.filt[f]  = set_id(bank_q[(FILT_SET0 + f)*BYTES_PER_SET + B_SIDH],
                                 bank_q[(FILT_SET0 + f)*BYTES_PER_SET + B_SIDL],
                                 bank_q[(FILT_SET0 + f)*BYTES_PER_SET + B_EID8],
                                 bank_q[(FILT_SET0 + f)*BYTES_PER_SET + B_EID0]);
    assign mif.extended_id_enable[f] = bank_q[(FILT_SET0 + f)*BYTES_PER_SET + B_SIDL][EXTENDED_ID_ENABLE_BIT];
  end
  assign mif.msg_ext = MSG_EXT;
  assign mif.msg_id  = MSG_EXT ? MSG_ID : {MSG_ID[STD_W-1:0], {EXT_W{1'b0}}};

  caf_match u_match (
    .mi (mif)
  );

  // acceptance only runs in normal mode; buffer 0 wins over buffer 1
  wire run_norm  = (cur_mode_q == MODE_NORMAL);
  wire buf0_hit  = |mif.hit[N_BUF0_FILT-1:0];
  wire buf1_hit  = |mif.hit[N_FILT-1:N_BUF0_FILT];
  wire accept    = MSG_VALID && run_norm && (buf0_hit || buf1_hit);
  wire take_buf1 = !buf0_hit;
  wire [FILT_IDX_W-1:0] hit_idx = take_buf1 ? first_hit(mif.hit, N_BUF0_FILT) : first_hit(mif.hit, 0);

  // accepted message report and filter hit status
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ACC_VALID  <= 1'b0;
      ACC_BUF    <= 1'b0;
      ACC_FILTER <= '0;
      rx0_hit_q  <= 1'b0;
      rx1_hit_q  <= '0;
    end else if (soft_rst_q) begin
      ACC_VALID  <= 1'b0;
      ACC_BUF    <= 1'b0;
      ACC_FILTER <= '0;
      rx0_hit_q  <= 1'b0;
      rx1_hit_q  <= '0;
    end else begin
      ACC_VALID <= accept;
      if (accept) begin
        ACC_BUF    <= take_buf1;
        ACC_FILTER <= hit_idx;
        if (take_buf1) rx1_hit_q <= hit_idx;
        else           rx0_hit_q <= hit_idx[0];
      end
    end
  end

  // bit timing: quantum divider and quantum counter, halted in configuration
  wire [BRP_W-1:0] baud_prescaler     = cfg1_q[BRP_W-1:0];
  wire [DIV_W-1:0] div     = tq_div(baud_prescaler);
  wire [QNT_W-1:0] seg_prop = seg_q(cfg2_q[PROP_LO +: SEG_W]);
  wire [QNT_W-1:0] seg_ps1  = seg_q(cfg2_q[PS1_LO +: SEG_W]);
  wire [QNT_W-1:0] seg_ps2  = seg_q(cfg3_q[PS2_LO +: SEG_W]);
  wire [QNT_W-1:0] bit_len  = QNT_W'(1) + seg_prop + seg_ps1 + seg_ps2;
  wire [QNT_W-1:0] samp_q   = seg_prop + seg_ps1; // last quantum of phase 1
  logic [DIV_W-1:0] tq_cnt_q;
  logic [QNT_W-1:0] qnt_q;
  wire tick = !in_cfg && (tq_cnt_q == div - DIV_W'(1));

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      tq_cnt_q <= '0;
      qnt_q    <= '0;
    end else if (in_cfg || soft_rst_q) begin
      tq_cnt_q <= '0;
      qnt_q    <= '0;
    end else if (tick) begin
      tq_cnt_q <= '0;
      qnt_q    <= (qnt_q == bit_len - QNT_W'(1)) ? '0 : qnt_q + QNT_W'(1);
    end else begin
      tq_cnt_q <= tq_cnt_q + DIV_W'(1);
    end
  end

  // registered timing strobes; bit start marks the sync quantum
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      TQ_TICK      <= 1'b0;
      BIT_START    <= 1'b0;
      SAMPLE_POINT <= 1'b0;
      CONFIG_MODE  <= 1'b1;
    end else begin
      TQ_TICK      <= tick;
      BIT_START    <= tick && (qnt_q == bit_len - QNT_W'(1));
      SAMPLE_POINT <= tick && (qnt_q == samp_q);
      CONFIG_MODE  <= in_cfg || soft_rst_q;
    end
  end

  // read mux; unmapped offsets read zero
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (ADDR)
      OFF_CTRL:   rd_mux = {req_mode_q, 5'h00};
      OFF_STAT:   rd_mux = {cur_mode_q, 4'h0, osc_rdy_q};
      OFF_CFG1:   rd_mux = cfg1_q;
      OFF_CFG2:   rd_mux = cfg2_q;
      OFF_CFG3:   rd_mux = cfg3_q;
      OFF_RX0CTL: rd_mux = {7'h00, rx0_hit_q};
      OFF_RX1CTL: rd_mux = {5'h00, rx1_hit_q};
      default:    rd_mux = hit_bank ? bank_q[bank_idx] : '0;
    endcase
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) RDATA <= '0;
    else        RDATA <= RD ? rd_mux : '0;
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  // helper: cycles since the previous quantum tick
  logic [DIV_W:0] gap_q;
  logic           gap_ok_q;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      gap_q    <= '0;
      gap_ok_q <= 1'b0;
    end else begin
      gap_q    <= TQ_TICK ? (DIV_W+1)'(1) : gap_q + (DIV_W+1)'(1);
      gap_ok_q <= in_cfg ? 1'b0 : (gap_ok_q || TQ_TICK);
    end
  end

  sequence s_soft_rst;
    WR && hit_reset ##1 soft_rst_q;
  endsequence
  sequence s_cfg_held;
    (cur_mode_q == MODE_CONFIG) [*2];
  endsequence

  a_reset_config: assert property (s_soft_rst |=> s_cfg_held)
    else $error("soft reset did not enter configuration mode");
  a_start_wait: assert property (s_soft_rst |=> !osc_rdy_q [*8])
    else $error("ready flag rose too early after reset");
  a_cfg_locked: assert property (WR && hit_cfg1 && !in_cfg && !soft_rst_q |=> $stable(cfg1_q))
    else $error("timing register changed outside configuration");
  a_bank_locked: assert property (WR && hit_bank && !in_cfg && !soft_rst_q
                                  |=> bank_q[$past(bank_idx)] == $past(bank_q[bank_idx]))
    else $error("mask or filter changed outside configuration");
  a_tq_period: assert property (TQ_TICK && gap_ok_q && !in_cfg |-> gap_q == (DIV_W+1)'(div))
    else $error("quantum period is not twice prescaler plus one");
  a_rx0_first: assert property (ACC_VALID && ACC_BUF |-> $past(!buf0_hit))
    else $error("buffer 1 took a message that buffer 0 matched");
  a_hit_report: assert property (ACC_VALID && ACC_BUF |-> rx1_hit_q == ACC_FILTER && ACC_FILTER >= 3'h2)
    else $error("buffer 1 filter hit bits wrong");
  a_extended_id_enable_fmt: assert property (ACC_VALID |-> mif.extended_id_enable[ACC_FILTER] == $past(MSG_EXT))
    else $error("filter accepted a frame of the wrong format");
  a_normal_only: assert property (ACC_VALID |-> $past(cur_mode_q) == MODE_NORMAL)
    else $error("message accepted outside normal mode");
endmodule
